// file: psp_pkg.sv
package psp_pkg;

  // ****************************************************************
  // Packet layout
  // ****************************************************************
  localparam int          RTP_HDR_BYTES = 12;      // Fixed RTP header
  localparam int          IPUDP_BYTES   = 28;      // IPv4 20 plus UDP 8
  localparam int          MTU_DEFAULT   = 1500;    // Typical network MTU
  localparam logic [15:0] LEN_BYTES     = 16'h0002; // Length field bytes
  localparam logic [15:0] BASIC_BYTES   = 16'h0019; // 200-bit basic block
  localparam logic [15:0] CHECK_BYTES   = 16'h0002; // Trailing check bytes
  localparam logic [3:0]  HDR_LAST      = 4'hB;    // Index of last RTP byte

  // ****************************************************************
  // Header field values
  // ****************************************************************
  localparam logic [1:0]  RTP_VERSION   = 2'h2;
  localparam logic        RTP_PADDING   = 1'h0;     // Never padded
  localparam logic [3:0]  RTP_CSRC_CNT  = 4'h0;
  localparam logic [6:0]  RTP_PT_PRE    = 7'h4D;    // Preamble payload type
  localparam logic [31:0] RTP_SSRC      = 32'h0000_0000;
  localparam logic [15:0] SEQ_RESET     = 16'h0000;
  localparam logic [31:0] DST_IP        = 32'hEF00_3330; // 239.0.51.48
  localparam logic [15:0] DST_PORT_BASE = 16'h7570;      // 30064
  localparam logic [15:0] PORT_STEP     = 16'h0064;      // 100 per channel

  // ****************************************************************
  // Check value defaults (polynomial is configurable)
  // ****************************************************************
  localparam logic [15:0] CRC_POLY_DEF  = 16'h1021;
  localparam logic [15:0] CRC_INIT_DEF  = 16'hFFFF;

  typedef enum logic [1:0] {PSP_IDLE, PSP_HDR, PSP_PAY} psp_state_e;

  // Per-preamble request from the scheduler
  typedef struct packed {
    logic [15:0] detail_len;   // Detail block bytes
    logic [31:0] seconds;      // Frame start seconds
    logic [31:0] nanoseconds;  // Frame start nanoseconds
    logic [1:0]  chan;         // Channel index for port offset
    logic        ext;          // A header extension follows
  } psp_cfg_s;

  // Complete state of the packetizer
  typedef struct packed {
    psp_state_e  state;
    logic [3:0]  hdr_idx;
    logic [15:0] pos;          // Byte index into payload structure
    logic [15:0] frag;         // Payload bytes in current packet
    logic [15:0] len;          // Value of length field
    logic [15:0] seq;
    logic [15:0] crc;
    logic [31:0] ts;
    logic        marker;
    logic        ext;
    logic [15:0] port;
    logic [15:0] pkt_len;      // RTP header plus fragment bytes
    logic        ovalid;
    logic [7:0]  odata;
    logic        ofirst;
    logic        olast;
    logic        late;
  } psp_reg_s;

endpackage

// file: psp_packetizer.sv
// Summary of operation
// - Payload: length, basic, detail, check, in order
// - Length counts following bytes, excluding check bytes
// - Check value covers length and both blocks
// - Destination 239.0.51.48, port 30064 plus offset
// - Split payload so each packet fits MTU
// - Marker set only on packet starting structure
// - Same timestamp across one packet set
// - Timestamp top 22 bits from seconds LSBs
// - Timestamp low 10 bits from nanoseconds
// - Extension bit follows presence of extension
// - Contributing-source count is zero
// - Payload type is 77
// - Synchronization source is zero
// - Padding and sequence follow standard RTP
// - Preamble sent before frame construction starts
module psp_packetizer #(
  parameter int          MTU      = psp_pkg::MTU_DEFAULT,
  parameter logic [15:0] CRC_POLY = psp_pkg::CRC_POLY_DEF,
  parameter logic [15:0] CRC_INIT = psp_pkg::CRC_INIT_DEF
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             start,       // Request a preamble
  input  wire psp_pkg::psp_cfg_s cfg,        // Held with start
  output logic                  start_ready, // Idle, request taken
  input  wire logic             in_valid,    // Signalling byte valid
  input  wire logic [7:0]       in_data,     // Basic then detail bytes
  output logic                  in_ready,
  input  wire logic             build_start, // Described frame build
  output logic                  late,        // Preamble was too late
  output logic                  out_valid,
  output logic [7:0]            out_data,    // RTP header then payload
  output logic                  out_first,   // First byte of packet
  output logic                  out_last,    // Last byte of packet
  input  wire logic             out_ready,
  output logic [31:0]           dst_ip,
  output logic [15:0]           dst_port,
  output logic [15:0]           pkt_len,     // RTP bytes of packet
  output logic                  busy
);

  // ****************************************************************
  // Constants and helpers
  // ****************************************************************
  // Largest fragment that keeps IP, UDP and RTP inside the MTU
  localparam logic [15:0] MAX_FRAG =
    16'(MTU - psp_pkg::IPUDP_BYTES - psp_pkg::RTP_HDR_BYTES);
  localparam logic [15:0] HDR_BYTES = 16'(psp_pkg::RTP_HDR_BYTES);

  // Bitwise CRC over one byte, MSB first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = (r << 1) ^ CRC_POLY;
      end else begin
        r = r << 1;
      end
    end
    return r;
  endfunction

  // RTP bytes of the packet that starts at payload index p
  function automatic logic [15:0] frag_len(input logic [15:0] total,
                                           input logic [15:0] p);
    logic [15:0] rem;
    rem = total - p;
    return ((rem > MAX_FRAG) ? MAX_FRAG : rem) + HDR_BYTES;
  endfunction

  psp_pkg::psp_reg_s st;       // Registered state
  psp_pkg::psp_reg_s next_st;  // Next state
  logic [15:0]       total;    // Whole payload structure bytes
  logic [15:0]       body_end; // First check byte index
  logic              adv;      // Output stage can take a byte
  logic              in_body;  // Current byte comes from the input
  logic [7:0]        hbyte;    // Current header byte
  logic              frag_end; // Current byte ends its packet

  assign body_end = st.len + psp_pkg::LEN_BYTES;
  assign total    = body_end + psp_pkg::CHECK_BYTES;
  assign adv      = !st.ovalid || out_ready;
  assign in_body  = (st.pos >= psp_pkg::LEN_BYTES) && (st.pos < body_end);
  assign frag_end = (st.pos + 16'h0001 == total)
                 || (st.frag + 16'h0001 == MAX_FRAG);

  // ****************************************************************
  // RTP header byte selection
  // ****************************************************************
  always_comb begin
    unique case (st.hdr_idx)
      4'h0: hbyte = {psp_pkg::RTP_VERSION, psp_pkg::RTP_PADDING,
                     st.ext, psp_pkg::RTP_CSRC_CNT};
      4'h1: hbyte = {st.marker, psp_pkg::RTP_PT_PRE};
      4'h2: hbyte = st.seq[15:8];
      4'h3: hbyte = st.seq[7:0];
      4'h4: hbyte = st.ts[31:24];
      4'h5: hbyte = st.ts[23:16];
      4'h6: hbyte = st.ts[15:8];
      4'h7: hbyte = st.ts[7:0];
      4'h8: hbyte = psp_pkg::RTP_SSRC[31:24];
      4'h9: hbyte = psp_pkg::RTP_SSRC[23:16];
      4'hA: hbyte = psp_pkg::RTP_SSRC[15:8];
      4'hB: hbyte = psp_pkg::RTP_SSRC[7:0];
      default: hbyte = 8'h00;                         // Index is 12 only in payload state, byte unused
    endcase
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_st  = st;
    in_ready = 1'b0;
    // Output byte leaves when the consumer takes it
    if (st.ovalid && out_ready) begin
      next_st.ovalid = 1'b0;
    end
    // A late build start is flagged; a new request clears it,
    // but a build start in the same cycle still wins
    if (start && st.state == psp_pkg::PSP_IDLE) begin
      next_st.late = 1'b0;
    end
    if (build_start && busy) begin
      next_st.late = 1'b1;
    end
    unique case (st.state)
      psp_pkg::PSP_IDLE: begin
        if (start) begin
          next_st.len    = psp_pkg::BASIC_BYTES + cfg.detail_len;
          next_st.ts     = {cfg.seconds[21:0],
                            cfg.nanoseconds[29:20]};
          next_st.marker = 1'b1;
          next_st.ext    = cfg.ext;
          next_st.port   = psp_pkg::DST_PORT_BASE
                         + 16'(PORT_MUL(cfg.chan));
          next_st.pos    = 16'h0000;
          next_st.frag   = 16'h0000;
          next_st.hdr_idx = 4'h0;
          next_st.crc    = CRC_INIT;
          next_st.pkt_len = frag_len(psp_pkg::BASIC_BYTES + cfg.detail_len
                          + psp_pkg::LEN_BYTES + psp_pkg::CHECK_BYTES,
                            16'h0000);
          next_st.state  = psp_pkg::PSP_HDR;
        end
      end
      psp_pkg::PSP_HDR: begin
        if (adv) begin
          next_st.ovalid  = 1'b1;
          next_st.odata   = hbyte;
          next_st.ofirst  = (st.hdr_idx == 4'h0);
          next_st.olast   = 1'b0;
          next_st.hdr_idx = st.hdr_idx + 4'h1;
          if (st.hdr_idx == psp_pkg::HDR_LAST) begin
            next_st.frag  = 16'h0000;
            next_st.state = psp_pkg::PSP_PAY;
          end
        end
      end
      psp_pkg::PSP_PAY: begin
        in_ready = adv && in_body;
        if (adv && (!in_body || in_valid)) begin
          next_st.ovalid = 1'b1;
          next_st.ofirst = 1'b0;
          next_st.olast  = frag_end;
          // Bytes leave strictly in structure order
          if (st.pos == 16'h0000) begin
            next_st.odata = st.len[15:8];
          end else if (st.pos == 16'h0001) begin
            next_st.odata = st.len[7:0];
          end else if (in_body) begin
            next_st.odata = in_data;
          end else if (st.pos == body_end) begin
            next_st.odata = st.crc[15:8];
          end else begin
            next_st.odata = st.crc[7:0];
          end
          if (st.pos < body_end) begin
            next_st.crc = crc_byte(st.crc,
              (st.pos == 16'h0000) ? st.len[15:8] :
              (st.pos == 16'h0001) ? st.len[7:0] : in_data);
          end
          next_st.pos  = st.pos + 16'h0001;
          next_st.frag = st.frag + 16'h0001;
          if (frag_end) begin
            next_st.seq     = st.seq + 16'h0001;
            next_st.marker  = 1'b0;
            next_st.hdr_idx = 4'h0;
            next_st.pkt_len = frag_len(total, st.pos + 16'h0001);
            next_st.state   = (st.pos + 16'h0001 == total) ?
                              psp_pkg::PSP_IDLE : psp_pkg::PSP_HDR;
          end
        end
      end
      default: next_st.state = psp_pkg::PSP_IDLE;
    endcase
  end

  // Channel port offset is channel times the step
  function automatic logic [15:0] PORT_MUL(input logic [1:0] c);
    return 16'(c * psp_pkg::PORT_STEP);
  endfunction

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st       <= '0;
      st.state <= psp_pkg::PSP_IDLE;
      st.seq   <= psp_pkg::SEQ_RESET;
      st.port  <= psp_pkg::DST_PORT_BASE;
      st.crc   <= CRC_INIT;
    end else begin
      st <= next_st;
    end
  end

  // Outputs other than dst_ip and in_ready come straight from the state register
  assign start_ready = (st.state == psp_pkg::PSP_IDLE);
  assign busy        = (st.state != psp_pkg::PSP_IDLE) || st.ovalid;
  assign late        = st.late;
  assign out_valid   = st.ovalid;
  assign out_data    = st.odata;
  assign out_first   = st.ofirst;
  assign out_last    = st.olast;
  assign dst_ip      = psp_pkg::DST_IP;
  assign dst_port    = st.port;
  assign pkt_len     = st.pkt_len;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence hdr_byte1_s;
    st.state == psp_pkg::PSP_HDR && st.hdr_idx == 4'h1 && adv;
  endsequence

  sequence first_pay_s;
    st.state == psp_pkg::PSP_PAY && st.pos == 16'h0000 && adv;
  endsequence

  // Second byte of a payload structure enters the output stage
  sequence second_pay_s;
    st.state == psp_pkg::PSP_PAY && st.pos == 16'h0001 && adv;
  endsequence

  marker_first_a: assert property (hdr_byte1_s |=>
      out_data[7] == (st.pos == 16'h0000))
    else $error("marker bit does not match packet start");
  pt_value_a: assert property (hdr_byte1_s |=>
      out_data[6:0] == 7'h4D)
    else $error("payload type is not 77");
  byte0_fixed_a: assert property (
      st.state == psp_pkg::PSP_HDR && st.hdr_idx == 4'h0 && adv |=>
      out_data[7:6] == 2'h2 && out_data[3:0] == 4'h0 && out_first)
    else $error("version or contributing count wrong");
  ext_bit_a: assert property (
      st.state == psp_pkg::PSP_HDR && st.hdr_idx == 4'h0 && adv |=>
      out_data[4] == st.ext && out_data[5] == 1'b0)
    else $error("extension or padding bit wrong");
  ts_stable_a: assert property (
      st.state != psp_pkg::PSP_IDLE ##1 st.state != psp_pkg::PSP_IDLE
      |-> $stable(st.ts))
    else $error("timestamp changed inside a packet set");
  ts_map_a: assert property (
      start && start_ready |=>
      st.ts == {$past(cfg.seconds[21:0]), $past(cfg.nanoseconds[29:20])})
    else $error("timestamp not taken from frame start time");
  // Length counts the basic block plus the detail block, never the check
  len_value_a: assert property (
      start && start_ready |=>
      st.len == 16'h0019 + $past(cfg.detail_len))
    else $error("length does not count the signalling bytes");
  len_field_a: assert property (first_pay_s |=>
      out_data == st.len[15:8])
    else $error("length high byte not first in payload");
  len_low_a: assert property (second_pay_s |=>
      out_data == st.len[7:0])
    else $error("length low byte not second in payload");
  frag_fits_a: assert property (
      st.state == psp_pkg::PSP_PAY |-> st.frag < MAX_FRAG)
    else $error("fragment exceeds network size");
  seq_step_a: assert property (
      st.state == psp_pkg::PSP_PAY && adv && frag_end &&
      (!in_body || in_valid) |=> st.seq == $past(st.seq) + 16'h0001)
    else $error("sequence did not step by one");
  port_val_a: assert property (
      start && start_ready |=>
      dst_port == 16'h7570 + 16'h0064 * 16'($past(cfg.chan)))
    else $error("destination port wrong");
  late_flag_a: assert property (
      build_start && busy |=> late)
    else $error("late preamble not flagged");
  // An on-time build start must leave the flag alone
  late_quiet_a: assert property (
      !late && !(build_start && busy) |=> !late)
    else $error("late flag set without a late build start");

endmodule // psp_packetizer

// file: psp_consumer.sv
module psp_consumer (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        stall,     // Back-pressure asked by the bench
  input  wire logic        out_valid,
  input  wire logic [7:0]  out_data,
  input  wire logic        out_first,
  input  wire logic        out_last,
  input  wire logic [15:0] pkt_len,
  output logic             out_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Reassembly state
  // ****************************************************************
  logic [95:0] hdr_q[$];   // Fixed header of each packet
  int          size_q[$];  // Bytes counted per packet
  int          plen_q[$];  // Announced length at first byte
  logic [7:0]  pay_q[$];   // Rebuilt payload structure
  logic [95:0] hdr;        // Header being shifted in
  logic [15:0] last_seq;   // Sequence of previous packet
  logic        seen;       // A previous packet exists
  int          cnt;        // Byte index within packet
  int          lost;       // Structures thrown away

  // Stalls are only as random as the bench makes them
  assign out_ready = !stall;

  // Take one byte per accepted beat; check order at header end
  always @(posedge ref_clk) begin
    if (rst) begin
      lost = 0;
      seen = 0;
    end else if (out_valid && out_ready) begin
      if (out_first) begin
        cnt = 0;
        plen_q.push_back(pkt_len);
      end
      if (cnt < 12) hdr = {hdr[87:0], out_data};
      // Gap or early marker: drop the old set's payload bytes, keep its headers
      if (cnt == 11 && ((seen && hdr[79:64] != last_seq + 16'h0001)
          || (hdr[87] && pay_q.size() > 0))) begin
        lost++;
        pay_q.delete();
      end
      // Rebuilt structure is what the transmitter reuses on air
      if (cnt >= 12) pay_q.push_back(out_data);
      cnt++;
      if (out_last) begin
        hdr_q.push_back(hdr);
        size_q.push_back(cnt);
        last_seq = hdr[79:64];
        seen = 1;
      end
    end
  end
endmodule // psp_consumer

// file: tb_psp_packetizer.sv
module tb_psp_packetizer;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int     MTU  = 80;        // Small MTU forces fragments
  localparam int     FRAG = MTU - 40;  // Largest fragment
  logic              ref_clk, rst, start, in_valid, build_start;
  logic              stall, stall_on;
  psp_pkg::psp_cfg_s cfg;
  logic [7:0]        in_data, out_data;
  logic              start_ready, in_ready, late, busy;
  logic              out_valid, out_first, out_last, out_ready;
  logic [31:0]       dst_ip, seed;
  logic [15:0]       dst_port, pkt_len, seq_exp;
  logic [7:0]        exp_q[$];
  int                failures, tests_run;

  psp_packetizer #(.MTU(MTU)) psp_packetizer_inst (
    .ref_clk(ref_clk), .rst(rst), .start(start), .cfg(cfg),
    .start_ready(start_ready), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .build_start(build_start), .late(late),
    .out_valid(out_valid), .out_data(out_data), .out_first(out_first),
    .out_last(out_last), .out_ready(out_ready), .dst_ip(dst_ip),
    .dst_port(dst_port), .pkt_len(pkt_len), .busy(busy));

  psp_consumer psp_consumer_inst (
    .ref_clk(ref_clk), .rst(rst), .stall(stall), .out_valid(out_valid),
    .out_data(out_data), .out_first(out_first), .out_last(out_last),
    .pkt_len(pkt_len), .out_ready(out_ready));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Bitwise check value, MSB first, no final inversion
  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i][b]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One whole preamble: request, feed bytes, drain, compare
  task automatic run_set(input logic [15:0] dl, input logic [1:0] ch,
                         input logic ext, input logic mk_late);
    logic [31:0] s, ns, ts;
    logic [95:0] h;
    logic [15:0] c;
    int n, k, tot, npk, sz;
    s = rnd();
    ns = rnd();
    ts = {s[21:0], ns[29:20]};
    tot = dl + 25;
    exp_q = {8'((tot >> 8) & 255), 8'(tot & 255)};
    for (k = 0; k < 50 && !start_ready; k++) @(negedge ref_clk);
    @(posedge ref_clk);
    start <= 1;
    cfg <= '{dl, s, ns, ch, ext};
    @(posedge ref_clk);
    start <= 0;
    in_valid <= 1;
    in_data <= 8'(rnd());
    @(negedge ref_clk);
    check("start_ready", 32'h0, start_ready);
    n = 0;
    // Hold each byte until an edge that sees in_ready high
    while (n < tot) begin
      @(negedge ref_clk);
      k = in_ready;
      @(posedge ref_clk);
      if (k) begin
        exp_q.push_back(in_data);
        n++;
        in_data <= 8'(rnd());
        if (n == tot) in_valid <= 0;
      end
    end
    if (mk_late) begin
      build_start <= 1;
      @(posedge ref_clk);
      build_start <= 0;
    end
    c = crc_of(exp_q);
    exp_q.push_back(c[15:8]);
    exp_q.push_back(c[7:0]);
    for (k = 0; k < 4000; k++) begin
      @(negedge ref_clk);
      if (!busy && psp_consumer_inst.pay_q.size() >= tot + 4) break;
    end
    npk = psp_consumer_inst.hdr_q.size();
    check("size", tot + 4, psp_consumer_inst.pay_q.size());
    foreach (exp_q[i])
      check("byte", exp_q[i], psp_consumer_inst.pay_q[i]);
    check("packets", (tot + 3 + FRAG) / FRAG, npk);
    foreach (psp_consumer_inst.hdr_q[j]) begin
      h = psp_consumer_inst.hdr_q[j];
      sz = psp_consumer_inst.size_q[j];
      check("version", 32'h2, h[95:94]);
      check("padding", 32'h0, h[93]);
      check("extension", ext, h[92]);
      check("source count", 32'h0, h[91:88]);
      check("marker", j == 0, h[87]);
      check("payload type", 32'h4D, h[86:80]);
      check("sequence", 16'(seq_exp + j), h[79:64]);
      check("timestamp", ts, h[63:32]);
      check("sync source", 32'h0, h[31:0]);
      check("pkt_len", sz, psp_consumer_inst.plen_q[j]);
      check("fits", 32'h1, sz <= FRAG + 12);
    end
    seq_exp += 16'(npk);
    check("dst_ip", 32'hEF00_3330, dst_ip);
    check("dst_port", 16'h7570 + 16'h0064 * ch, dst_port);
    check("late", mk_late, late);
    check("lost sets", 32'h0, psp_consumer_inst.lost);
    psp_consumer_inst.hdr_q.delete();
    psp_consumer_inst.size_q.delete();
    psp_consumer_inst.plen_q.delete();
    psp_consumer_inst.pay_q.delete();
    $display("set done detail %0d", dl);
  endtask

  // ****************************************************************
  // Clock, stalls, watchdog and main sequence
  // ****************************************************************
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Random back-pressure on the stream side
  always @(posedge ref_clk) stall <= stall_on && (rnd() % 4 == 0);

  initial begin
    #100000;
    failures++;
    end_of_test();
  end

  initial begin
    logic [31:0] r;
    seed = 32'h01F7_D1C7;
    {rst, start, in_valid, build_start, stall, stall_on} = 6'h20;
    cfg = '0;
    in_data = 8'h00;
    seq_exp = 16'h0000;
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    @(negedge ref_clk);
    check("port at reset", 16'h7570, dst_port);
    run_set(16'h0000, 2'h0, 1'b0, 1'b0); // Single packet
    // A build start while idle is on time and must not flag late
    @(posedge ref_clk);
    build_start <= 1'b1;
    @(posedge ref_clk);
    build_start <= 1'b0;
    @(negedge ref_clk);
    check("late when idle", 32'h0, late);
    run_set(16'h0033, 2'h1, 1'b1, 1'b1); // Exactly two full fragments
    run_set(16'h0034, 2'h2, 1'b0, 1'b0); // One byte spills over
    stall_on = 1;
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      run_set(16'(r % 100), 2'(i), r[8], r[9]);
    end
    end_of_test();
  end
endmodule // tb_psp_packetizer
